// [logic/session_pkg.sv]
/*
 * session layer constants: tags, lengths, outcome codes, id layout and handle values.
 * assumes a byte-serial session unit stream from a lower transport layer.
 */
package session_pkg;
    // ========================================
    // unit tags
    localparam logic [7:0] TAG_PREFIX = 8'h90;
    localparam logic [7:0] TAG_OPEN_Q = 8'h91;
    localparam logic [7:0] TAG_OPEN_R = 8'h92;
    localparam logic [7:0] TAG_CLOSE_Q = 8'h95;
    localparam logic [7:0] TAG_CLOSE_R = 8'h96;
    localparam logic [7:0] TAG_LAST = 8'h96;
    // ========================================
    // fixed object lengths
    localparam logic [7:0] LEN_PREFIX = 8'h02;
    localparam logic [7:0] LEN_OPEN_Q = 8'h04;
    localparam logic [7:0] LEN_OPEN_R = 8'h07;
    localparam logic [7:0] LEN_CLOSE_Q = 8'h02;
    localparam logic [7:0] LEN_CLOSE_R = 8'h03;
    // ========================================
    // outcome codes
    localparam logic [7:0] ST_OK = 8'h00;
    localparam logic [7:0] ST_ABSENT = 8'hf0;
    localparam logic [7:0] ST_UNAVAIL = 8'hf1;
    localparam logic [7:0] ST_VERSION = 8'hf2;
    localparam logic [7:0] ST_BUSY = 8'hf3;
    // ========================================
    // resource id layout: class/type upper 26 bits, version low 6
    localparam int VER_W = 6;
    localparam logic [15:0] HANDLE_NONE = 16'h0000;
    localparam logic [15:0] HANDLE_FIRST = 16'h0001;
endpackage

// [logic/session_resource.sv]
/*
 * one host resource slot: declared id, availability, session limit and usage count.
 * assumes the parent pulses take/give only after checking the returned flags.
 */
`timescale 1ns/1ns
module session_resource #(
    parameter logic [31:0] RES_ID = 32'h00010041,
    parameter int MAX_SESS = 1
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // query
    input wire logic [31:0] i_req_id,
    input wire logic i_avail,
    // usage updates
    input wire logic i_take,
    input wire logic i_give,
    // answer
    output logic o_match,
    output logic [7:0] o_status,
    output logic [31:0] o_bound_id
);
    typedef struct packed {
        logic [7:0] used;
    } res_state_t;
    res_state_t st;
    res_state_t next_st;
    logic [5:0] req_ver;
    logic [5:0] decl_ver;

    // class and type must equal the declared resource
    assign o_match = (i_req_id[31:session_pkg::VER_W] == RES_ID[31:session_pkg::VER_W]);
    assign req_ver = i_req_id[session_pkg::VER_W-1:0];
    assign decl_ver = RES_ID[session_pkg::VER_W-1:0];

    // outcome and bound version
    always_comb begin
        o_bound_id = i_req_id;
        if (!o_match) begin
            o_status = session_pkg::ST_ABSENT;
        end else if (!i_avail) begin
            o_status = session_pkg::ST_UNAVAIL;
        end else if (req_ver > decl_ver) begin
            o_status = session_pkg::ST_VERSION;
        end else if (st.used >= 8'(MAX_SESS)) begin
            o_status = session_pkg::ST_BUSY;
        end else begin
            o_status = session_pkg::ST_OK;
            if (req_ver == '0) begin
                o_bound_id = RES_ID;
            end else begin
                o_bound_id = i_req_id;
            end
        end
    end

    // usage count
    always_comb begin
        next_st = st;
        if (i_take && !i_give) begin
            next_st.used = st.used + 8'h01;
        end else if (i_give && !i_take && st.used != 8'h00) begin
            next_st.used = st.used - 8'h01;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// [logic/session_layer_handler.sv]
/*
 * host-side session layer engine: parses incoming session units byte by byte,
 * keeps the session table, and emits open/close replies and prefixed messages.
 * assumes the transport below delivers one unit per i_in_last-terminated burst.
 */
`timescale 1ns/1ns
module session_layer_handler #(
    parameter int NSESS = 4,
    parameter logic [31:0] RES0_ID = 32'h00010041,
    parameter logic [31:0] RES1_ID = 32'h00400081,
    parameter int RES1_MAX = 2
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // resource availability
    input wire logic [1:0] i_res_avail,
    // incoming unit bytes
    input wire logic i_in_valid,
    input wire logic [7:0] i_in_data,
    input wire logic i_in_last,
    // incoming message handed up
    output logic o_msg_valid,
    output logic [7:0] o_msg_data,
    output logic o_msg_last,
    output logic [15:0] o_msg_handle,
    // outgoing message from above
    input wire logic i_app_valid,
    input wire logic [15:0] i_app_handle,
    input wire logic [7:0] i_app_data,
    input wire logic i_app_last,
    output logic o_app_ready,
    // outgoing unit bytes
    output logic o_out_valid,
    output logic [7:0] o_out_data,
    output logic o_out_last,
    input wire logic i_out_ready,
    // status
    output logic o_drop
);
    typedef enum {RX_TAG, RX_LEN, RX_OBJ, RX_BODY, RX_SKIP, RX_EXEC} rx_t;
    typedef enum {TX_IDLE, TX_REPLY, TX_APP} tx_t;
    typedef struct packed {
        rx_t rx;
        tx_t tx;
        logic [7:0] tag;
        logic [7:0] len;
        logic [7:0] cnt;
        logic [31:0] obj;
        logic [79:0] rep;
        logic [3:0] rep_len;
        logic [3:0] rep_idx;
        logic [15:0] msg_handle;
        logic msg_valid;
        logic [7:0] msg_data;
        logic msg_last;
        logic drop;
        logic [15:0] next_handle;
        logic [NSESS-1:0] open;
        logic [NSESS-1:0] res_sel;
        logic [NSESS*16-1:0] handles;
    } state_t;
    state_t s;
    state_t n;

    // ========================================
    // resource slots
    logic [1:0] r_match;
    logic [7:0] r_status [2];
    logic [31:0] r_bound [2];
    logic [1:0] r_take;
    logic [1:0] r_give;

    session_resource #(.RES_ID(RES0_ID), .MAX_SESS(1)) u_res0 (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_req_id(s.obj), .i_avail(i_res_avail[0]),
        .i_take(r_take[0]), .i_give(r_give[0]),
        .o_match(r_match[0]), .o_status(r_status[0]), .o_bound_id(r_bound[0]));
    session_resource #(.RES_ID(RES1_ID), .MAX_SESS(RES1_MAX)) u_res1 (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_req_id(s.obj), .i_avail(i_res_avail[1]),
        .i_take(r_take[1]), .i_give(r_give[1]),
        .o_match(r_match[1]), .o_status(r_status[1]), .o_bound_id(r_bound[1]));

    // ========================================
    // helpers
    function automatic logic [7:0] fixed_len(input logic [7:0] tag);
        case (tag)
            session_pkg::TAG_PREFIX: fixed_len = session_pkg::LEN_PREFIX;
            session_pkg::TAG_OPEN_Q: fixed_len = session_pkg::LEN_OPEN_Q;
            session_pkg::TAG_CLOSE_Q: fixed_len = session_pkg::LEN_CLOSE_Q;
            session_pkg::TAG_CLOSE_R: fixed_len = session_pkg::LEN_CLOSE_R;
            default: fixed_len = 8'hff;
        endcase
    endfunction

    logic known_tag;
    logic [NSESS-1:0] hit;
    logic free_found;
    int free_idx;
    int hit_idx;
    logic [7:0] sel_status;
    logic [31:0] sel_bound;
    logic [1:0] sel_res;

    // unit accepted only for host-bound tags and matching length
    assign known_tag = (s.tag == session_pkg::TAG_PREFIX) || (s.tag == session_pkg::TAG_OPEN_Q)
        || (s.tag == session_pkg::TAG_CLOSE_Q) || (s.tag == session_pkg::TAG_CLOSE_R);

    // table lookup by handle held in obj low bits
    always_comb begin
        hit = '0;
        hit_idx = 0;
        free_found = 1'b0;
        free_idx = 0;
        for (int i = NSESS - 1; i >= 0; i--) begin
            if (s.open[i] && s.handles[i*16 +: 16] == s.obj[15:0]) begin
                hit[i] = 1'b1;
                hit_idx = i;
            end
            if (!s.open[i]) begin
                free_found = 1'b1;
                free_idx = i;
            end
        end
    end

    // first declared resource that matches decides the answer
    always_comb begin
        sel_res = 2'b00;
        if (r_match[0]) begin
            sel_status = r_status[0];
            sel_bound = r_bound[0];
            sel_res = 2'b01;
        end else if (r_match[1]) begin
            sel_status = r_status[1];
            sel_bound = r_bound[1];
            sel_res = 2'b10;
        end else begin
            sel_status = session_pkg::ST_ABSENT;
            sel_bound = s.obj;
        end
    end

    // usage counts move only on the cycle the unit really executes, never while it waits for tx
    assign r_take = (s.rx == RX_EXEC && s.tx == TX_IDLE && s.tag == session_pkg::TAG_OPEN_Q
        && sel_status == session_pkg::ST_OK && free_found) ? sel_res : 2'b00;
    assign r_give = (s.rx == RX_EXEC && s.tx == TX_IDLE && hit != '0 && (s.tag == session_pkg::TAG_CLOSE_Q
        || (s.tag == session_pkg::TAG_CLOSE_R && s.obj[23:16] == session_pkg::ST_OK)))
        ? {s.res_sel[hit_idx], ~s.res_sel[hit_idx]} : 2'b00;

    // ========================================
    // next state
    always_comb begin
        n = s;
        n.msg_valid = 1'b0;
        n.msg_last = 1'b0;
        n.drop = 1'b0;
        case (s.rx)
            RX_TAG: if (i_in_valid) begin
                n.tag = i_in_data;
                n.obj = '0;
                n.cnt = 8'h00;
                n.rx = i_in_last ? RX_TAG : RX_LEN;
            end
            RX_LEN: if (i_in_valid) begin
                n.len = i_in_data;
                if (!known_tag || i_in_data != fixed_len(s.tag)) begin
                    n.drop = 1'b1;
                    n.rx = i_in_last ? RX_TAG : RX_SKIP;
                end else begin
                    n.rx = i_in_last ? RX_TAG : RX_OBJ;
                end
            end
            RX_OBJ: if (i_in_valid) begin
                n.obj = {s.obj[23:0], i_in_data};
                n.cnt = s.cnt + 8'h01;
                if (s.cnt + 8'h01 == s.len) begin
                    n.rx = (s.tag == session_pkg::TAG_PREFIX) ? RX_BODY : RX_EXEC;
                    if (s.tag == session_pkg::TAG_PREFIX && i_in_last) n.rx = RX_TAG;
                end else if (i_in_last) begin
                    n.drop = 1'b1;
                    n.rx = RX_TAG;
                end
            end
            RX_BODY: if (i_in_valid) begin
                // message passed up with its handle when known
                n.msg_valid = |hit;
                n.msg_data = i_in_data;
                n.msg_last = i_in_last;
                n.msg_handle = s.obj[15:0];
                if (i_in_last) n.rx = RX_TAG;
            end
            RX_SKIP: if (i_in_valid && i_in_last) begin
                n.rx = RX_TAG;
            end
            RX_EXEC: if (s.tx == TX_IDLE) begin
                n.rx = RX_TAG;
                n.rep_idx = '0;
                if (s.tag == session_pkg::TAG_OPEN_Q) begin
                    n.tx = TX_REPLY;
                    n.rep_len = 4'd9;
                    n.rep = {session_pkg::TAG_OPEN_R, session_pkg::LEN_OPEN_R,
                        (sel_status == session_pkg::ST_OK && !free_found) ? session_pkg::ST_BUSY : sel_status,
                        sel_bound, (sel_status == session_pkg::ST_OK && free_found)
                        ? s.next_handle : session_pkg::HANDLE_NONE, 8'h00};
                    if (sel_status == session_pkg::ST_OK && free_found) begin
                        n.open[free_idx] = 1'b1;
                        n.res_sel[free_idx] = sel_res[1];
                        n.handles[free_idx*16 +: 16] = s.next_handle;
                        // skip zero on wrap
                        n.next_handle = (s.next_handle == 16'hffff) ? session_pkg::HANDLE_FIRST
                            : s.next_handle + 16'h0001;
                    end
                end else if (s.tag == session_pkg::TAG_CLOSE_Q) begin
                    n.tx = TX_REPLY;
                    n.rep_len = 4'd5;
                    n.rep = {session_pkg::TAG_CLOSE_R, session_pkg::LEN_CLOSE_R,
                        (|hit) ? session_pkg::ST_OK : session_pkg::ST_ABSENT,
                        s.obj[15:0], 40'h0};
                    if (|hit) n.open[hit_idx] = 1'b0;
                end else if (s.tag == session_pkg::TAG_CLOSE_R && s.obj[23:16] == session_pkg::ST_OK) begin
                    if (|hit) n.open[hit_idx] = 1'b0;
                end
            end
            default: n.rx = RX_TAG;
        endcase
        // transmit side: replies first, then prefixed application messages
        case (s.tx)
            TX_IDLE: if (i_app_valid && s.rx != RX_EXEC) begin
                n.tx = TX_APP;
                n.rep_idx = '0;
                n.rep = {session_pkg::TAG_PREFIX, session_pkg::LEN_PREFIX, i_app_handle, 48'h0};
            end
            TX_REPLY: if (i_out_ready) begin
                n.rep = {s.rep[71:0], 8'h00};
                n.rep_idx = s.rep_idx + 4'd1;
                if (s.rep_idx + 4'd1 == s.rep_len) n.tx = TX_IDLE;
            end
            TX_APP: if (i_out_ready) begin
                if (s.rep_idx < 4'd4) begin
                    n.rep = {s.rep[71:0], 8'h00};
                    n.rep_idx = s.rep_idx + 4'd1;
                end else if (i_app_valid && i_app_last) begin
                    n.tx = TX_IDLE;
                end
            end
            default: n.tx = TX_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '0;
            s.next_handle <= session_pkg::HANDLE_FIRST;
        end else begin
            s <= n;
        end
    end

    // ========================================
    // outputs; only tags 0x90, 0x92, 0x96 leave here
    assign o_out_valid = (s.tx == TX_REPLY) || (s.tx == TX_APP && (s.rep_idx < 4'd4 || i_app_valid));
    assign o_out_data = (s.tx == TX_APP && s.rep_idx >= 4'd4) ? i_app_data : s.rep[79:72];
    assign o_out_last = (s.tx == TX_REPLY) ? (s.rep_idx + 4'd1 == s.rep_len)
        : (s.tx == TX_APP && s.rep_idx >= 4'd4 && i_app_last);
    assign o_app_ready = (s.tx == TX_APP) && (s.rep_idx >= 4'd4) && i_out_ready;
    assign o_msg_valid = s.msg_valid;
    assign o_msg_data = s.msg_data;
    assign o_msg_last = s.msg_last;
    assign o_msg_handle = s.msg_handle;
    assign o_drop = s.drop;

    // ========================================
    // checks
    sequence s_open_exec;
        s.rx == RX_EXEC && s.tx == TX_IDLE && s.tag == session_pkg::TAG_OPEN_Q;
    endsequence
    property p_open_tag;
        @(posedge i_clk) disable iff (!i_rst_n) s_open_exec |=> o_out_valid && o_out_data == session_pkg::TAG_OPEN_R;
    endproperty
    a_open_tag: assert property (p_open_tag) else $error("open reply tag wrong");
    property p_no_zero;
        @(posedge i_clk) disable iff (!i_rst_n) s.next_handle != session_pkg::HANDLE_NONE;
    endproperty
    a_no_zero: assert property (p_no_zero) else $error("zero handle pending");
    property p_close_tag;
        @(posedge i_clk) disable iff (!i_rst_n)
        s.rx == RX_EXEC && s.tx == TX_IDLE && s.tag == session_pkg::TAG_CLOSE_Q
        |=> o_out_valid && o_out_data == session_pkg::TAG_CLOSE_R
        ##1 o_out_data == ($past(i_out_ready) ? session_pkg::LEN_CLOSE_R : session_pkg::TAG_CLOSE_R);
    endproperty
    a_close_tag: assert property (p_close_tag) else $error("close reply header wrong");
    property p_drop_keep;
        @(posedge i_clk) disable iff (!i_rst_n) o_drop |-> $stable(s.open);
    endproperty
    a_drop_keep: assert property (p_drop_keep) else $error("drop changed table");
    property p_tag_range;
        @(posedge i_clk) disable iff (!i_rst_n) o_out_valid && s.rep_idx == 4'd0 && s.tx != TX_IDLE
        |-> o_out_data >= session_pkg::TAG_PREFIX && o_out_data <= session_pkg::TAG_LAST && o_out_data != session_pkg::TAG_OPEN_Q;
    endproperty
    a_tag_range: assert property (p_tag_range) else $error("reserved tag sent");
    property p_prefix;
        @(posedge i_clk) disable iff (!i_rst_n) $rose(s.tx == TX_APP) |-> o_out_data == session_pkg::TAG_PREFIX;
    endproperty
    a_prefix: assert property (p_prefix) else $error("message without prefix");
    property p_msg_known;
        @(posedge i_clk) disable iff (!i_rst_n) $rose(o_msg_valid) |-> $past(s.rx) == RX_BODY;
    endproperty
    a_msg_known: assert property (p_msg_known) else $error("message outside body");
    property p_close_frees;
        @(posedge i_clk) disable iff (!i_rst_n)
        s.rx == RX_EXEC && s.tx == TX_IDLE && s.tag == session_pkg::TAG_CLOSE_Q && hit != '0 |=> (s.open & $past(hit)) == '0;
    endproperty
    a_close_frees: assert property (p_close_frees) else $error("closed entry kept");
endmodule

// [bench/card_model.sv]
/*
 * removable-module side model: sends session units byte by byte, collects host bytes.
 * assumes the host engine takes one inbound byte per clock and pulses its drop flag.
 */
`timescale 1ns/1ns
module card_model (
    // clock
    input wire logic i_clk,
    // toward the host
    output logic o_in_valid,
    output logic [7:0] o_in_data,
    output logic o_in_last,
    output logic o_out_ready,
    // from the host
    input wire logic i_out_valid,
    input wire logic [7:0] i_out_data,
    input wire logic i_out_last,
    input wire logic i_msg_valid,
    input wire logic [7:0] i_msg_data,
    input wire logic i_msg_last,
    input wire logic [15:0] i_msg_handle,
    input wire logic i_drop
);
    // ========================================
    // state
    logic slow = 1'b0;
    logic [8:0] rx[$];
    logic [24:0] mq[$];
    int drops = 0;
    initial begin
        o_in_valid = 1'b0;
        o_in_data = 8'h00;
        o_in_last = 1'b0;
        o_out_ready = 1'b1;
    end
    // ========================================
    // one unit, tag first; released data flips so no stale byte looks valid
    task automatic send(input logic [7:0] b[$]);
        foreach (b[i]) begin
            @(posedge i_clk);
            #1;
            o_in_valid = 1'b1;
            o_in_data = b[i];
            o_in_last = (i == b.size() - 1);
        end
        @(posedge i_clk);
        #1;
        o_in_valid = 1'b0;
        o_in_last = 1'b0;
        o_in_data = ~o_in_data;
    endtask
    // capture moved bytes with end flag, message bytes with handle
    always @(posedge i_clk) begin
        if (i_out_valid && o_out_ready)
            rx.push_back({i_out_last, i_out_data});
        if (i_msg_valid)
            mq.push_back({i_msg_last, i_msg_handle, i_msg_data});
        if (i_drop)
            drops++;
    end
    // a slow card halves the drain rate to shake out hold bugs
    always @(posedge i_clk) begin
        #1;
        o_out_ready = slow ? ~o_out_ready : 1'b1;
    end
endmodule

// [bench/session_layer_handler_test.sv]
/*
 * self-checking bench for the host session engine, driving it through the card model.
 * assumes default resource parameters: single-session id 00010041, two-session id 00400081.
 */
`timescale 1ns/1ns
module session_layer_handler_test;
    // ========================================
    // signals
    logic i_clk, i_rst_n, i_in_valid, i_in_last, i_app_valid, i_app_last, i_out_ready;
    logic [1:0] i_res_avail;
    logic [7:0] i_in_data, i_app_data, o_msg_data, o_out_data;
    logic [15:0] i_app_handle, o_msg_handle, h0, h1, hx;
    logic o_msg_valid, o_msg_last, o_app_ready, o_out_valid, o_out_last, o_drop;
    logic [7:0] st;
    logic [31:0] bid;
    int failures = 0;
    int n_compared = 0;
    session_layer_handler i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_res_avail(i_res_avail),
        .i_in_valid(i_in_valid), .i_in_data(i_in_data), .i_in_last(i_in_last),
        .o_msg_valid(o_msg_valid), .o_msg_data(o_msg_data), .o_msg_last(o_msg_last),
        .o_msg_handle(o_msg_handle), .i_app_valid(i_app_valid), .i_app_handle(i_app_handle),
        .i_app_data(i_app_data), .i_app_last(i_app_last), .o_app_ready(o_app_ready),
        .o_out_valid(o_out_valid), .o_out_data(o_out_data), .o_out_last(o_out_last),
        .i_out_ready(i_out_ready), .o_drop(o_drop));
    card_model p (.i_clk(i_clk), .o_in_valid(i_in_valid), .o_in_data(i_in_data),
        .o_in_last(i_in_last), .o_out_ready(i_out_ready), .i_out_valid(o_out_valid),
        .i_out_data(o_out_data), .i_out_last(o_out_last), .i_msg_valid(o_msg_valid),
        .i_msg_data(o_msg_data), .i_msg_last(o_msg_last), .i_msg_handle(o_msg_handle),
        .i_drop(o_drop));
    // free-running clock
    always #5 i_clk = ~i_clk;
    // ========================================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (failures == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // bounded wait on the reply queue or the message queue
    task automatic wait_q(input int n, input bit msgs);
        int k;
        k = 0;
        while ((msgs ? p.mq.size() : p.rx.size()) < n && k < 300) begin
            @(posedge i_clk);
            #2;
            k++;
        end
        if (k == 300) begin
            failures++;
            final_report();
        end
    endtask
    task automatic open_q(input logic [31:0] id);
        p.rx.delete();
        p.send('{8'h91, 8'h04, id[31:24], id[23:16], id[15:8], id[7:0]});
        wait_q(9, 1'b0);
        check(p.rx[0], 9'h092);
        check(p.rx[1], 9'h007);
        check(p.rx[8][8], 1'b1);
        st = p.rx[2][7:0];
        bid = {p.rx[3][7:0], p.rx[4][7:0], p.rx[5][7:0], p.rx[6][7:0]};
        hx = {p.rx[7][7:0], p.rx[8][7:0]};
        if (st === 8'h00)
            check(hx === 16'h0000, 1'b0);
    endtask
    task automatic close_q(input logic [15:0] h);
        p.rx.delete();
        p.send('{8'h95, 8'h02, h[15:8], h[7:0]});
        wait_q(5, 1'b0);
        check(p.rx[0], 9'h096);
        check(p.rx[1], 9'h003);
        check({p.rx[4][8], p.rx[3][7:0], p.rx[4][7:0]}, {1'b1, h});
        st = p.rx[2][7:0];
    endtask
    // ========================================
    // scenarios; all requested class/type pairs are declared ones except the absent probe
    task automatic t_open();
        open_q(32'h00010041);
        check(st, 8'hf1);
        @(posedge i_clk);
        #1;
        i_res_avail = 2'b11;
        open_q(32'h00010041);
        check({st, bid}, {8'h00, 32'h00010041});
        h0 = hx;
        open_q(32'h00010041);
        check(st, 8'hf3);
        open_q(32'h00400082);
        check(st, 8'hf2);
        open_q(32'h00400080);
        check({st, bid}, {8'h00, 32'h00400081});
        h1 = hx;
        open_q(32'h00400081);
        check({st, bid}, {8'h00, 32'h00400081});
        check(hx === h1 || hx === h0, 1'b0);
        open_q(32'h00400081);
        check(st === 8'h00, 1'b0);
        open_q(32'h00990041);
        check({st, bid}, {8'hf0, 32'h00990041});
    endtask
    // reserved tag and a close with a bad length must both vanish
    task automatic t_drop();
        p.rx.delete();
        p.send('{8'h93, 8'h00});
        p.send('{8'h95, 8'h03, h0[15:8], h0[7:0], 8'h00});
        repeat (4) @(posedge i_clk);
        check(p.drops, 2);
        check(p.rx.size(), 0);
    endtask
    task automatic t_msg();
        p.mq.delete();
        p.send('{8'h90, 8'h02, h1[15:8], h1[7:0], 8'ha1, 8'ha2, 8'ha3});
        wait_q(3, 1'b1);
        check(p.mq[0], {1'b0, h1, 8'ha1});
        check(p.mq[2], {1'b1, h1, 8'ha3});
        p.mq.delete();
        p.send('{8'h90, 8'h02, 8'h00, 8'h77, 8'hb1});
        repeat (10) @(posedge i_clk);
        check(p.mq.size(), 0);
    endtask
    // outbound message while the card stalls every other cycle
    task automatic t_app();
        logic [7:0] d[2];
        logic [8:0] e[6];
        int i, k;
        d = '{8'hc1, 8'hc2};
        e = '{9'h090, 9'h002, {1'b0, h1[15:8]}, {1'b0, h1[7:0]}, 9'h0c1, 9'h1c2};
        i = 0;
        k = 0;
        p.rx.delete();
        p.slow = 1'b1;
        @(posedge i_clk);
        #1;
        i_app_valid = 1'b1;
        i_app_handle = h1;
        i_app_data = d[0];
        while (i < 2 && k < 100) begin
            @(posedge i_clk);
            k++;
            if (o_app_ready) begin
                i++;
                #1;
                i_app_data = (i < 2) ? d[1] : ~d[1];
                i_app_last = (i == 1);
                i_app_valid = (i < 2);
            end
        end
        check(i, 2);
        if (i < 2)
            final_report();
        wait_q(6, 1'b0);
        foreach (e[j])
            check(p.rx[j], e[j]);
    endtask
    task automatic t_close();
        close_q(h0);
        check(st, 8'h00);
        close_q(h0);
        check(st, 8'hf0);
        close_q(16'h0055);
        check(st, 8'hf0);
        p.slow = 1'b0;
        open_q(32'h00010041);
        check(st, 8'h00);
        // a close reply from the card frees both the table entry and the single-session slot
        h0 = hx;
        p.send('{8'h96, 8'h03, 8'h00, h0[15:8], h0[7:0]});
        repeat (4) @(posedge i_clk);
        check(p.drops, 2);
        check(p.rx.size(), 9);
        open_q(32'h00010041);
        check(st, 8'h00);
    endtask
    // ========================================
    // main sequence
    initial begin
        i_clk = 1'b0;
        i_rst_n = 1'b0;
        i_res_avail = 2'b10;
        i_app_valid = 1'b0;
        i_app_handle = 16'h0000;
        i_app_data = 8'h00;
        i_app_last = 1'b0;
        repeat (4) @(posedge i_clk);
        #1;
        i_rst_n = 1'b1;
        t_open();
        t_drop();
        t_msg();
        t_app();
        t_close();
        final_report();
    end
endmodule
